/* pkg/sys_ctrl_pkg.sv */
// package for the exception system control block: offsets, field positions, reset values
// assumes a 32-bit classic wishbone slave with word-aligned registers
package sys_ctrl_pkg;

  localparam logic [7:0] OFS_ICSR = 8'h04;
  localparam logic [7:0] OFS_VTOR = 8'h08;
  localparam logic [7:0] OFS_AIRCR = 8'h0C;
  localparam logic [7:0] OFS_SCR = 8'h10;
  localparam logic [7:0] OFS_CCR = 8'h14;

  // interrupt_control_state fields
  localparam int DS_SET_BIT = 28;
  localparam int DS_CLR_BIT = 27;
  localparam int ST_SET_BIT = 26;
  localparam int ST_CLR_BIT = 25;
  localparam int ISR_PEND_BIT = 22;
  localparam int PEND_NUM_LSB = 12;
  localparam int RET_BASE_BIT = 11;
  localparam int ACT_NUM_LSB = 0;
  localparam int EXC_NUM_W = 9;

  // vector table offset keeps bits [29:7]
  localparam int TBL_LSB = 7;
  localparam int TBL_MSB = 29;

  // application_interrupt_reset_control fields
  localparam int KEY_LSB = 16;
  localparam logic [15:0] WRITE_KEY = 16'h05FA;
  localparam logic [15:0] READ_KEY = 16'hFA05;
  localparam int ENDIAN_BIT = 15;
  localparam int PRIGRP_LSB = 8;
  localparam int SYSRST_BIT = 2;

  // system_sleep_control fields
  localparam int SEV_PEND_BIT = 4;
  localparam int DEEP_SLEEP_BIT = 2;
  localparam int SLEEP_EXIT_BIT = 1;

  localparam logic [31:0] CCR_RESET = 32'h0000_0200;
  localparam logic [31:0] CCR_MASK = 32'h0000_031B;

  localparam logic [8:0] EXC_IRQ_BASE = 9'h010;
  localparam logic [8:0] EXC_DEFERRED = 9'h00E;
  localparam logic [8:0] EXC_TICK = 9'h00F;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic deep_sleep;
    logic sleep_on_exit;
    logic send_event_on_pend;
  } sleep_cfg_t;

endpackage

/* rtl/exception_system_control.sv */
// exception system control registers with the pend logic and sleep/event control
// assumes the core supplies exception state from the same clock, synchronous reset
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module exception_system_control #(
  parameter int IRQ_COUNT = 32
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire sys_ctrl_pkg::wb_req_t wb_req,
  output sys_ctrl_pkg::wb_rsp_t wb_rsp,
  input wire logic [8:0] status_exception_number,
  input wire logic [8:0] highest_pending_raw,
  input wire logic [7:0] highest_pending_group,
  input wire logic pending_is_fault,
  input wire logic [7:0] base_priority_mask,
  input wire logic fault_mask_a,
  input wire logic any_irq_pending,
  input wire logic preempted_active,
  input wire logic [IRQ_COUNT-1:0] irq_pending_lines,
  input wire logic [IRQ_COUNT-1:0] irq_enable_lines,
  input wire logic event_in,
  input wire logic wait_for_event,
  input wire logic handler_return_to_thread,
  input wire logic deferred_service_taken,
  input wire logic system_tick_taken,
  input wire logic system_tick_fire,
  input wire logic endian_strap,
  input wire logic [7:0] priority_probe,
  output logic deferred_service_exception,
  output logic system_tick_exception,
  output logic [8:0] device_irq_index,
  output logic [29:0] vector_table_base,
  output logic [2:0] priority_grouping,
  output logic [7:0] group_priority_of_probe,
  output logic system_reset_request,
  output logic endian_big,
  output logic wake_core,
  output logic sleep_now,
  output logic deep_sleep_now,
  output logic [31:0] configuration_control
);

  if (IRQ_COUNT < 1 || IRQ_COUNT > 496)
  begin : g_irq_count_check
    $error("IRQ_COUNT out of range");
  end

  localparam int TBL_W = sys_ctrl_pkg::TBL_MSB - sys_ctrl_pkg::TBL_LSB + 1;
  logic ds_pend_q;
  logic st_pend_q;
  logic [TBL_W-1:0] tbl_q;
  logic [2:0] prigrp_q;
  logic endian_q;
  logic endian_cap_q;
  logic sysrst_q;
  sys_ctrl_pkg::sleep_cfg_t sleep_q;
  logic [31:0] ccr_q;
  logic event_latch_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [IRQ_COUNT-1:0] pend_prev_q;

  // group value: keep bits above the binary point
  function automatic logic [7:0] group_of(input logic [7:0] pri, input logic [2:0] grp);
    logic [7:0] mask;
    mask = 8'hFF << (grp + 3'h1);
    if (grp == 3'h7)
      mask = 8'h00;
    return pri & mask;
  endfunction

  logic req;
  logic wr;
  logic [31:0] wdat;
  logic key_ok;
  assign req = wb_req.cyc & wb_req.stb & ~ack_q;
  assign wr = req & wb_req.we & (wb_req.sel == 4'hF);
  assign wdat = wb_req.dat;
  assign key_ok = wdat[31:16] == sys_ctrl_pkg::WRITE_KEY;

  logic wr_icsr;
  logic wr_vtor;
  logic wr_aircr;
  logic wr_scr;
  logic wr_ccr;
  assign wr_icsr = wr & (wb_req.adr == sys_ctrl_pkg::OFS_ICSR);
  assign wr_vtor = wr & (wb_req.adr == sys_ctrl_pkg::OFS_VTOR);
  assign wr_aircr = wr & (wb_req.adr == sys_ctrl_pkg::OFS_AIRCR) & key_ok;
  assign wr_scr = wr & (wb_req.adr == sys_ctrl_pkg::OFS_SCR);
  assign wr_ccr = wr & (wb_req.adr == sys_ctrl_pkg::OFS_CCR);

  // deferred service: only software sets it; taking the exception clears it
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      ds_pend_q <= 1'b0;
    else if (wr_icsr && wdat[sys_ctrl_pkg::DS_SET_BIT])
      ds_pend_q <= 1'b1;
    else if ((wr_icsr && wdat[sys_ctrl_pkg::DS_CLR_BIT]) || deferred_service_taken)
      ds_pend_q <= 1'b0;
  end

  // tick: the timer event wins over a simultaneous software clear
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      st_pend_q <= 1'b0;
    else if (system_tick_fire || (wr_icsr && wdat[sys_ctrl_pkg::ST_SET_BIT]))
      st_pend_q <= 1'b1;
    else if ((wr_icsr && wdat[sys_ctrl_pkg::ST_CLR_BIT]) || system_tick_taken)
      st_pend_q <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      tbl_q <= '0;
    else if (wr_vtor)
      tbl_q <= wdat[sys_ctrl_pkg::TBL_MSB:sys_ctrl_pkg::TBL_LSB];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      prigrp_q <= 3'h0;
    else if (wr_aircr)
      prigrp_q <= wdat[sys_ctrl_pkg::PRIGRP_LSB +: 3];
  end

  // the strap is a pin: two flops before anything reads it; they run through reset
  logic strap_meta_q;
  logic strap_sync_q;
  always_ff @(posedge clock)
  begin
    strap_meta_q <= endian_strap;
    strap_sync_q <= strap_meta_q;
  end

  // endianness is a strap taken once just after reset release
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      endian_q <= 1'b0;
      endian_cap_q <= 1'b0;
    end
    else if (!endian_cap_q)
    begin
      endian_q <= strap_sync_q;
      endian_cap_q <= 1'b1;
    end
  end

  // one-cycle request; the flop clears itself at the next edge
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      sysrst_q <= 1'b0;
    else
      sysrst_q <= wr_aircr & wdat[sys_ctrl_pkg::SYSRST_BIT];
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      sleep_q <= '0;
    else if (wr_scr)
    begin
      sleep_q.send_event_on_pend <= wdat[sys_ctrl_pkg::SEV_PEND_BIT];
      sleep_q.deep_sleep <= wdat[sys_ctrl_pkg::DEEP_SLEEP_BIT];
      sleep_q.sleep_on_exit <= wdat[sys_ctrl_pkg::SLEEP_EXIT_BIT];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      ccr_q <= sys_ctrl_pkg::CCR_RESET;
    else if (wr_ccr)
      ccr_q <= wdat & sys_ctrl_pkg::CCR_MASK;
  end

  // new pending edges, gated by the send-event-on-pend choice
  logic [IRQ_COUNT-1:0] wake_mask;
  logic new_pend;
  assign wake_mask = sleep_q.send_event_on_pend ? '1 : irq_enable_lines;
  assign new_pend = |(irq_pending_lines & ~pend_prev_q & wake_mask);

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      pend_prev_q <= '0;
    else
      pend_prev_q <= irq_pending_lines;
  end

  // latch events outside a wait so the next wait completes at once
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      event_latch_q <= 1'b0;
    else if (event_in || new_pend)
      event_latch_q <= 1'b1;
    else if (wait_for_event)
      event_latch_q <= 1'b0;
  end

  assign wake_core = event_latch_q | event_in | new_pend;

  logic [8:0] pend_num;
  logic masked;
  logic [7:0] bp_group;
  assign bp_group = group_of(base_priority_mask, prigrp_q);
  assign masked = !pending_is_fault
                  && (fault_mask_a
                      || (base_priority_mask != 8'h00 && highest_pending_group >= bp_group));
  assign pend_num = masked ? 9'h000 : highest_pending_raw;

  logic [31:0] icsr_rd;
  always_comb
  begin
    icsr_rd = 32'h0000_0000;
    icsr_rd[sys_ctrl_pkg::DS_SET_BIT] = ds_pend_q;
    icsr_rd[sys_ctrl_pkg::ST_SET_BIT] = st_pend_q;
    icsr_rd[sys_ctrl_pkg::ISR_PEND_BIT] = any_irq_pending;
    icsr_rd[sys_ctrl_pkg::PEND_NUM_LSB +: 9] = pend_num;
    icsr_rd[sys_ctrl_pkg::RET_BASE_BIT] = !preempted_active;
    icsr_rd[sys_ctrl_pkg::ACT_NUM_LSB +: 9] = status_exception_number;
  end

  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (wb_req.adr)
      sys_ctrl_pkg::OFS_ICSR: rd_mux = icsr_rd;
      sys_ctrl_pkg::OFS_VTOR: rd_mux = {2'b00, tbl_q, 7'h00};
      sys_ctrl_pkg::OFS_AIRCR: rd_mux = {sys_ctrl_pkg::READ_KEY, endian_q, 4'h0,
                                         prigrp_q, 8'h00};
      sys_ctrl_pkg::OFS_SCR: rd_mux = {27'h0, sleep_q.send_event_on_pend, 1'b0,
                                       sleep_q.deep_sleep, sleep_q.sleep_on_exit, 1'b0};
      sys_ctrl_pkg::OFS_CCR: rd_mux = ccr_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // every address is acked one cycle later; unmapped ones read zero
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      rdata_q <= 32'h0000_0000;
    else if (req)
      rdata_q <= rd_mux;
  end

  assign wb_rsp.ack = ack_q;
  assign wb_rsp.dat = rdata_q;

  assign deferred_service_exception = ds_pend_q;
  assign system_tick_exception = st_pend_q;
  assign device_irq_index = status_exception_number - sys_ctrl_pkg::EXC_IRQ_BASE;
  assign vector_table_base = {tbl_q, 7'h00};
  assign priority_grouping = prigrp_q;
  assign group_priority_of_probe = group_of(priority_probe, prigrp_q);
  assign system_reset_request = sysrst_q;
  assign endian_big = endian_q;
  assign sleep_now = handler_return_to_thread & sleep_q.sleep_on_exit;
  assign deep_sleep_now = sleep_now & sleep_q.deep_sleep;
  assign configuration_control = ccr_q;

  AST_DS_CLEAR: assert property (@(posedge clock) disable iff (!rst_b)
    wr_icsr && wdat[sys_ctrl_pkg::DS_CLR_BIT] && !wdat[sys_ctrl_pkg::DS_SET_BIT] |=> !ds_pend_q)
    else $error("deferred pend not cleared");
  AST_DS_SET: assert property (@(posedge clock) disable iff (!rst_b)
    !(wr_icsr && wdat[sys_ctrl_pkg::DS_SET_BIT]) && !ds_pend_q |=> !ds_pend_q)
    else $error("deferred pend set without write");
  AST_ST_SET: assert property (@(posedge clock) disable iff (!rst_b)
    wr_icsr && wdat[sys_ctrl_pkg::ST_SET_BIT] |=> st_pend_q)
    else $error("tick pend not set");
  AST_ST_CLR: assert property (@(posedge clock) disable iff (!rst_b)
    wr_icsr && wdat[sys_ctrl_pkg::ST_CLR_BIT] && !wdat[sys_ctrl_pkg::ST_SET_BIT]
    && !system_tick_fire |=> !st_pend_q)
    else $error("tick pend not cleared");
  AST_KEY: assert property (@(posedge clock) disable iff (!rst_b)
    wr && wb_req.adr == sys_ctrl_pkg::OFS_AIRCR && !key_ok |=> $stable(prigrp_q))
    else $error("unkeyed write changed grouping");
  AST_UNKEYED_RST: assert property (@(posedge clock) disable iff (!rst_b)
    wr && wb_req.adr == sys_ctrl_pkg::OFS_AIRCR && !key_ok |=> !system_reset_request)
    else $error("unkeyed write requested reset");
  AST_KEY_READ: assert property (@(posedge clock) disable iff (!rst_b)
    req && wb_req.adr == sys_ctrl_pkg::OFS_AIRCR
    |=> ack_q && rdata_q[31:16] == sys_ctrl_pkg::READ_KEY)
    else $error("key read wrong");
  AST_RST_SET: assert property (@(posedge clock) disable iff (!rst_b)
    wr_aircr && wdat[sys_ctrl_pkg::SYSRST_BIT] |=> system_reset_request)
    else $error("reset request not raised");
  AST_RST_PULSE: assert property (@(posedge clock) disable iff (!rst_b)
    system_reset_request |=> !system_reset_request)
    else $error("reset request not a pulse");
  AST_EVT_LATCH: assert property (@(posedge clock) disable iff (!rst_b)
    event_in && !wait_for_event |=> wake_core)
    else $error("event not latched");
  AST_VTOR_LOW: assert property (@(posedge clock) disable iff (!rst_b)
    req && wb_req.adr == sys_ctrl_pkg::OFS_VTOR |=> rdata_q[sys_ctrl_pkg::TBL_LSB-1:0] == '0)
    else $error("table offset low bits set");
  AST_ISR_FLAG: assert property (@(posedge clock) disable iff (!rst_b)
    req && wb_req.adr == sys_ctrl_pkg::OFS_ICSR
    |=> rdata_q[sys_ctrl_pkg::ISR_PEND_BIT] == $past(any_irq_pending))
    else $error("interrupt pending flag wrong");
  AST_RET_BASE: assert property (@(posedge clock) disable iff (!rst_b)
    req && wb_req.adr == sys_ctrl_pkg::OFS_ICSR
    |=> rdata_q[sys_ctrl_pkg::RET_BASE_BIT] == !$past(preempted_active))
    else $error("return to base wrong");
  AST_ACT_NUM: assert property (@(posedge clock) disable iff (!rst_b)
    req && wb_req.adr == sys_ctrl_pkg::OFS_ICSR
    |=> rdata_q[sys_ctrl_pkg::ACT_NUM_LSB +: 9] == $past(status_exception_number))
    else $error("active number wrong");
  AST_SCR_RSVD: assert property (@(posedge clock) disable iff (!rst_b)
    req && wb_req.adr == sys_ctrl_pkg::OFS_SCR
    |=> rdata_q[31:5] == '0 && rdata_q[3] == 1'b0 && rdata_q[0] == 1'b0)
    else $error("sleep control reserved bits set");

endmodule
`default_nettype wire

/* testbench/exception_system_control_tb.sv */
// self-checking bench for the exception system control block
// assumes the block answers a classic wishbone cycle one edge after taking it
`timescale 1ns/1ps
`default_nettype none
module exception_system_control_tb;
  logic clock = 0;
  logic rst_b = 0;
  sys_ctrl_pkg::wb_req_t wb_req = '0;
  sys_ctrl_pkg::wb_rsp_t wb_rsp;
  logic [8:0] status_exception_number = '0;
  logic [8:0] highest_pending_raw = 9'h020;
  logic [7:0] highest_pending_group = 8'h80;
  logic [7:0] base_priority_mask = '0;
  logic [7:0] priority_probe = 8'hB7;
  logic [31:0] irq_pending_lines = '0;
  logic [31:0] irq_enable_lines = 32'h2;
  logic pending_is_fault = 0, fault_mask_a = 0, any_irq_pending = 0, preempted_active = 0;
  logic event_in = 0, wait_for_event = 0, handler_return_to_thread = 0;
  logic deferred_service_taken = 0, system_tick_taken = 0, system_tick_fire = 0;
  logic endian_strap = 0;
  logic deferred_service_exception, system_tick_exception, system_reset_request, endian_big;
  logic wake_core, sleep_now, deep_sleep_now;
  logic [8:0] device_irq_index;
  logic [29:0] vector_table_base;
  logic [2:0] priority_grouping;
  logic [7:0] group_priority_of_probe;
  logic [31:0] configuration_control;
  int mismatches = 0;
  int num_checks = 0;
  logic [31:0] q;
  logic rr, a;

  exception_system_control #(.IRQ_COUNT(32)) i_exception_system_control (
    .clock, .rst_b, .wb_req, .wb_rsp, .status_exception_number, .highest_pending_raw,
    .highest_pending_group, .pending_is_fault, .base_priority_mask, .fault_mask_a,
    .any_irq_pending, .preempted_active, .irq_pending_lines, .irq_enable_lines, .event_in,
    .wait_for_event, .handler_return_to_thread, .deferred_service_taken, .system_tick_taken,
    .system_tick_fire, .endian_strap, .priority_probe, .deferred_service_exception,
    .system_tick_exception, .device_irq_index, .vector_table_base, .priority_grouping,
    .group_priority_of_probe, .system_reset_request, .endian_big, .wake_core, .sleep_now,
    .deep_sleep_now, .configuration_control
  );

  always #20 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // request held until ack is seen high; released at the following edge
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clock);
    wb_req <= '{1'b1, 1'b1, we, 4'hF, adr, d};
    // no local limit: only the watchdog ends a wait that never sees ack
    do
    begin
      @(posedge clock);
      #1;
    end while (wb_rsp.ack !== 1'b1);
    q = wb_rsp.dat;
    rr = system_reset_request;
    @(posedge clock);
    wb_req <= '0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    xfer(1'b1, adr, d);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    xfer(1'b0, adr, 32'h0);
    check(q, exp);
  endtask

  task automatic pulse_wfe();
    @(posedge clock) wait_for_event <= 1;
    @(posedge clock) wait_for_event <= 0;
  endtask

  task automatic t_reset();
    rd(sys_ctrl_pkg::OFS_CCR, sys_ctrl_pkg::CCR_RESET);
    rd(sys_ctrl_pkg::OFS_AIRCR, 32'hFA05_0000);
    rd(sys_ctrl_pkg::OFS_VTOR, 32'h0);
    rd(8'h40, 32'h0);
    wr(sys_ctrl_pkg::OFS_CCR, 32'hFFFF_FFFF);
    rd(sys_ctrl_pkg::OFS_CCR, sys_ctrl_pkg::CCR_MASK);
    check(configuration_control, sys_ctrl_pkg::CCR_MASK);
    check(endian_big, 0);
    $display("test reset values done");
  endtask

  task automatic t_pend();
    wr(sys_ctrl_pkg::OFS_ICSR, 32'h1000_0000);
    xfer(1'b0, sys_ctrl_pkg::OFS_ICSR, 0);
    check(q & 32'hFDFF_FFFF, 32'h1002_0800);
    wr(sys_ctrl_pkg::OFS_ICSR, 32'h0);
    check(deferred_service_exception, 1);
    wr(sys_ctrl_pkg::OFS_ICSR, 32'h0800_0000);
    check(deferred_service_exception, 0);
    wr(sys_ctrl_pkg::OFS_ICSR, 32'h1000_0000);
    @(posedge clock) deferred_service_taken <= 1;
    @(posedge clock) deferred_service_taken <= 0;
    #1 check(deferred_service_exception, 0);
    wr(sys_ctrl_pkg::OFS_ICSR, 32'h0400_0000);
    xfer(1'b0, sys_ctrl_pkg::OFS_ICSR, 0);
    check(q & 32'hFDFF_FFFF, 32'h0402_0800);
    wr(sys_ctrl_pkg::OFS_ICSR, 32'h0200_0000);
    check(system_tick_exception, 0);
    @(posedge clock) system_tick_fire <= 1;
    @(posedge clock) system_tick_fire <= 0;
    #1 check(system_tick_exception, 1);
    @(posedge clock) system_tick_taken <= 1;
    @(posedge clock) system_tick_taken <= 0;
    #1 check(system_tick_exception, 0);
    $display("test pend bits done");
  endtask

  task automatic st_case(input logic [8:0] sen, input logic pa, input logic ai,
                         input logic fm, input logic pf, input logic [7:0] bp,
                         input logic [8:0] num);
    @(posedge clock);
    status_exception_number <= sen;
    preempted_active <= pa;
    any_irq_pending <= ai;
    fault_mask_a <= fm;
    pending_is_fault <= pf;
    base_priority_mask <= bp;
    xfer(1'b0, sys_ctrl_pkg::OFS_ICSR, 0);
    check(q & 32'hFDFF_FFFF, {9'h0, ai, 1'b0, num, !pa, 2'b0, sen});
    check(device_irq_index, 9'(sen - 9'h010));
  endtask

  task automatic t_status();
    st_case(9'h013, 1, 1, 0, 0, 8'h00, 9'h020);
    st_case(9'h013, 0, 1, 1, 0, 8'h00, 9'h000);
    st_case(9'h013, 0, 0, 1, 1, 8'h00, 9'h020);
    st_case(9'h000, 0, 1, 0, 0, 8'h40, 9'h000);
    st_case(9'h000, 0, 1, 0, 0, 8'hC0, 9'h020);
    $display("test status fields done");
  endtask

  task automatic t_vtor();
    wr(sys_ctrl_pkg::OFS_VTOR, 32'hFFFF_FFFF);
    rd(sys_ctrl_pkg::OFS_VTOR, 32'h3FFF_FF80);
    wr(sys_ctrl_pkg::OFS_VTOR, 32'h2000_0080);
    check(vector_table_base, 30'h2000_0080);
    $display("test table offset done");
  endtask

  task automatic t_aircr();
    logic [7:0] m;
    wr(sys_ctrl_pkg::OFS_AIRCR, 32'h0000_0704);
    rd(sys_ctrl_pkg::OFS_AIRCR, 32'hFA05_0000);
    check(rr | system_reset_request | priority_grouping, 0);
    for (int g = 0; g < 8; g++)
    begin
      wr(sys_ctrl_pkg::OFS_AIRCR, 32'h05FA_0000 | (g << 8));
      rd(sys_ctrl_pkg::OFS_AIRCR, 32'hFA05_0000 | (g << 8));
      m = 8'hFF << (g + 1);
      check(group_priority_of_probe, 8'hB7 & m);
    end
    wr(sys_ctrl_pkg::OFS_AIRCR, 32'h05FA_0004);
    check(rr, 1);
    rd(sys_ctrl_pkg::OFS_AIRCR, 32'hFA05_0000);
    check(rr, 0);
    $display("test key control done");
  endtask

  task automatic t_sleep();
    logic [31:0] v [3] = '{32'h6, 32'h2, 32'h0};
    wr(sys_ctrl_pkg::OFS_SCR, 32'hFFFF_FFFF);
    rd(sys_ctrl_pkg::OFS_SCR, 32'h16);
    foreach (v[i])
    begin
      wr(sys_ctrl_pkg::OFS_SCR, v[i]);
      @(posedge clock) handler_return_to_thread <= 1;
      #1 check(sleep_now, v[i][1]);
      check(deep_sleep_now, v[i][2]);
      @(posedge clock) handler_return_to_thread <= 0;
    end
    $display("test sleep control done");
  endtask

  task automatic t_wake();
    pulse_wfe();
    @(posedge clock) irq_pending_lines <= 32'h1;
    #1 a = wake_core;
    @(posedge clock) #1 a |= wake_core;
    check(a, 0);
    @(posedge clock) irq_pending_lines <= 32'h0;
    wr(sys_ctrl_pkg::OFS_SCR, 32'h10);
    @(posedge clock) irq_pending_lines <= 32'h1;
    #1 a = wake_core;
    @(posedge clock) #1 a |= wake_core;
    check(a, 1);
    pulse_wfe();
    @(posedge clock) event_in <= 1;
    @(posedge clock) event_in <= 0;
    @(posedge clock) #1 check(wake_core, 1);
    pulse_wfe();
    #1 check(wake_core, 0);
    $display("test wake events done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // the whole sequence needs well under a thousand cycles
  initial
  begin
    #(40 * 4000);
    mismatches++;
    complete_run();
  end

  initial
  begin
    repeat (3) @(posedge clock);
    rst_b <= 1;
    t_reset();
    t_pend();
    t_status();
    t_vtor();
    t_aircr();
    t_sleep();
    t_wake();
    complete_run();
  end
endmodule
`default_nettype wire
